// [inc/stt_pkg.sv]
package stt_pkg;

    // ------------------------------------------------------------
    // Register byte addresses (one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] STT_OFS_CTRL0 = 8'h00;
    localparam logic [7:0] STT_OFS_CTRL1 = 8'h04;
    localparam logic [7:0] STT_OFS_CNT_LO = 8'h08;
    localparam logic [7:0] STT_OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] STT_OFS_CMPA_LO = 8'h10;
    localparam logic [7:0] STT_OFS_CMPA_HI = 8'h14;
    localparam logic [7:0] STT_OFS_CMPP = 8'h18;
    localparam logic [7:0] STT_OFS_FLAGS = 8'h1C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STT_RST_CTRL0 = 8'h00;
    localparam logic [7:0] STT_RST_CTRL1 = 8'h00;
    localparam logic [7:0] STT_RST_CMP = 8'h00;
    localparam logic [15:0] STT_RST_CNT = 16'h0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STT_C0_PAU = 7;
    localparam int STT_C0_CKS = 4;
    localparam int STT_C0_RUN = 3;
    localparam int STT_C1_MODE = 6;
    localparam int STT_C1_PFS = 4;
    localparam int STT_C1_OC = 3;
    localparam int STT_C1_INV = 2;
    localparam int STT_C1_DPX = 1;
    localparam int STT_C1_CCLR = 0;
    localparam int STT_FL_A = 0;
    localparam int STT_FL_P = 1;

    // ------------------------------------------------------------
    // Modes and selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        STT_MODE_CMP = 2'b00,
        STT_MODE_UNDEF = 2'b01,
        STT_MODE_PWM = 2'b10,
        STT_MODE_TMR = 2'b11
    } stt_mode_t;

    typedef enum logic [2:0] {
        STT_CKS_SYS4 = 3'b000,
        STT_CKS_SYS = 3'b001,
        STT_CKS_HS16 = 3'b010,
        STT_CKS_HS64 = 3'b011,
        STT_CKS_LS_A = 3'b100,
        STT_CKS_LS_B = 3'b101,
        STT_CKS_EXT_R = 3'b110,
        STT_CKS_EXT_F = 3'b111
    } stt_cks_t;

    localparam logic [1:0] STT_PFS_KEEP = 2'b00;
    localparam logic [1:0] STT_PFS_LOW = 2'b01;
    localparam logic [1:0] STT_PFS_HIGH = 2'b10;
    localparam logic [1:0] STT_PFS_TOGGLE = 2'b11;

    // Prescaler terminal counts and the full counter period
    localparam logic [1:0] STT_SYS4_LAST = 2'h3;
    localparam logic [5:0] STT_HS16_LAST = 6'h0F;
    localparam logic [5:0] STT_HS64_LAST = 6'h3F;
    localparam logic [16:0] STT_FULL_PERIOD = 17'h1_0000;

    localparam logic [1:0] STT_RESP_OKAY = 2'b00;
    localparam logic [1:0] STT_RESP_SLVERR = 2'b10;

endpackage

// [logic/stt_timer.sv]
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module stt_timer
    import stt_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hs_clk_tick,
    input wire logic ls_clk_tick,
    input wire logic ext_clock_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic timer_output_pin,
    output logic timer_output_oe,
    output logic compare_a_flag,
    output logic compare_p_flag
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] ctrl0_ff;
    logic [7:0] ctrl1_ff;
    logic [15:0] cmpa_ff;
    logic [7:0] cmpp_ff;
    logic [15:0] cnt_ff;
    logic run_prev_ff;
    logic lvl_ff;
    logic [1:0] sys4_ff;
    logic [5:0] hs_ff;
    logic ext_s1_ff;
    logic ext_s2_ff;
    logic ext_s3_ff;

    logic ctrl_run;
    logic ctrl_pau;
    stt_cks_t ctrl_cks;
    stt_mode_t ctrl_mode;
    logic [1:0] ctrl_pfs;
    logic ctrl_oc;
    logic ctrl_inv;
    logic ctrl_dpx;
    logic ctrl_cclr;

    assign ctrl_run = ctrl0_ff[STT_C0_RUN];
    assign ctrl_pau = ctrl0_ff[STT_C0_PAU];
    assign ctrl_cks = stt_cks_t'(ctrl0_ff[STT_C0_CKS +: 3]);
    assign ctrl_mode = stt_mode_t'(ctrl1_ff[STT_C1_MODE +: 2]);
    assign ctrl_pfs = ctrl1_ff[STT_C1_PFS +: 2];
    assign ctrl_oc = ctrl1_ff[STT_C1_OC];
    assign ctrl_inv = ctrl1_ff[STT_C1_INV];
    assign ctrl_dpx = ctrl1_ff[STT_C1_DPX];
    assign ctrl_cclr = ctrl1_ff[STT_C1_CCLR];

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic [7:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_strb_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic wr_do;
    logic wr_hit;

    // A write completes one cycle after both halves are held
    assign wr_do = aw_held_ff && w_held_ff && !s_axi_bvalid;

    function automatic logic addr_known(input logic [7:0] a);
        unique case (a)
            STT_OFS_CTRL0, STT_OFS_CTRL1, STT_OFS_CNT_LO, STT_OFS_CNT_HI,
            STT_OFS_CMPA_LO, STT_OFS_CMPA_HI, STT_OFS_CMPP,
            STT_OFS_FLAGS: addr_known = 1'b1;
            default: addr_known = 1'b0;
        endcase
    endfunction

    assign wr_hit = wr_do && w_strb_ff && addr_known(aw_addr_ff);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end else if (wr_do) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 8'h00;
            w_strb_ff <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata[7:0];
            w_strb_ff <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end else if (wr_do) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= STT_RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(aw_addr_ff) ? STT_RESP_OKAY
                                                   : STT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl0_ff <= STT_RST_CTRL0;
            ctrl1_ff <= STT_RST_CTRL1;
            cmpa_ff <= {STT_RST_CMP, STT_RST_CMP};
            cmpp_ff <= STT_RST_CMP;
        end else if (wr_hit) begin
            unique case (aw_addr_ff)
                STT_OFS_CTRL0: ctrl0_ff <= {w_data_ff[7:3], 3'b000};
                STT_OFS_CTRL1: ctrl1_ff <= w_data_ff;
                STT_OFS_CMPA_LO: cmpa_ff[7:0] <= w_data_ff;
                STT_OFS_CMPA_HI: cmpa_ff[15:8] <= w_data_ff;
                STT_OFS_CMPP: cmpp_ff <= w_data_ff;
                default: ;
            endcase
        end
    end

    logic [7:0] rd_byte;
    logic ar_take;
    assign ar_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        unique case (s_axi_araddr)
            STT_OFS_CTRL0: rd_byte = {ctrl0_ff[7:3], 3'b000};
            STT_OFS_CTRL1: rd_byte = ctrl1_ff;
            STT_OFS_CNT_LO: rd_byte = cnt_ff[7:0];
            STT_OFS_CNT_HI: rd_byte = cnt_ff[15:8];
            STT_OFS_CMPA_LO: rd_byte = cmpa_ff[7:0];
            STT_OFS_CMPA_HI: rd_byte = cmpa_ff[15:8];
            STT_OFS_CMPP: rd_byte = cmpp_ff;
            STT_OFS_FLAGS: rd_byte = {6'b00_0000, compare_p_flag,
                                      compare_a_flag};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= STT_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= addr_known(s_axi_araddr) ? STT_RESP_OKAY
                                                     : STT_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Count tick sources
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sys4_ff <= 2'h0;
            hs_ff <= 6'h00;
        end else begin
            sys4_ff <= sys4_ff + 2'h1;
            if (hs_clk_tick) begin
                hs_ff <= hs_ff + 6'h01;
            end
        end
    end

    // First stage feeds only the second; edges seen on stages 2 and 3
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_ff <= 1'b0;
            ext_s2_ff <= 1'b0;
            ext_s3_ff <= 1'b0;
        end else begin
            ext_s1_ff <= ext_clock_pin;
            ext_s2_ff <= ext_s1_ff;
            ext_s3_ff <= ext_s2_ff;
        end
    end

    logic src_tick;
    always_comb begin
        unique case (ctrl_cks)
            STT_CKS_SYS4: src_tick = (sys4_ff == STT_SYS4_LAST);
            STT_CKS_SYS: src_tick = 1'b1;
            STT_CKS_HS16: src_tick = hs_clk_tick &&
                                     (hs_ff[3:0] == STT_HS16_LAST[3:0]);
            STT_CKS_HS64: src_tick = hs_clk_tick && (hs_ff == STT_HS64_LAST);
            STT_CKS_LS_A, STT_CKS_LS_B: src_tick = ls_clk_tick;
            STT_CKS_EXT_R: src_tick = ext_s2_ff && !ext_s3_ff;
            STT_CKS_EXT_F: src_tick = !ext_s2_ff && ext_s3_ff;
        endcase
    end

    // ------------------------------------------------------------
    // Counter and comparators
    // ------------------------------------------------------------
    logic run_rise;
    logic cnt_tick;
    logic [16:0] cnt_inc;
    logic [16:0] p_period;
    logic [16:0] a_period;
    logic p_hit;
    logic a_hit;
    logic do_clear;
    logic set_a;
    logic set_p;

    assign run_rise = ctrl_run && !run_prev_ff;
    // A paused or stopped counter sees no ticks
    assign cnt_tick = src_tick && ctrl_run && run_prev_ff &&
                      !ctrl_pau;
    assign cnt_inc = {1'b0, cnt_ff} + 17'h0_0001;
    assign p_period = (cmpp_ff == 8'h00) ? STT_FULL_PERIOD
                                         : {1'b0, cmpp_ff, 8'h00};
    assign a_period = (cmpa_ff == 16'h0000) ? STT_FULL_PERIOD
                                            : {1'b0, cmpa_ff};
    assign p_hit = (cnt_inc == p_period);
    // A zero compare A value never raises its flag
    assign a_hit = (cmpa_ff != 16'h0000) && (cnt_inc == {1'b0, cmpa_ff});

    always_comb begin
        if (ctrl_mode == STT_MODE_PWM) begin
            do_clear = ctrl_dpx ? a_hit : p_hit;
        end else begin
            do_clear = ctrl_cclr ? a_hit : p_hit;
        end
    end

    assign set_a = cnt_tick && a_hit;
    assign set_p = cnt_tick && p_hit &&
                   !(ctrl_cclr && ctrl_mode != STT_MODE_PWM);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= STT_RST_CNT;
            run_prev_ff <= 1'b0;
        end else begin
            run_prev_ff <= ctrl_run;
            if (run_rise) begin
                cnt_ff <= STT_RST_CNT;
            end else if (cnt_tick) begin
                // Overflow wraps to zero by itself
                cnt_ff <= do_clear ? STT_RST_CNT : cnt_inc[15:0];
            end
        end
    end

    // Sticky flags, write one to clear; a new match beats the clear
    logic clr_a;
    logic clr_p;
    assign clr_a = wr_hit && aw_addr_ff == STT_OFS_FLAGS &&
                   w_data_ff[STT_FL_A];
    assign clr_p = wr_hit && aw_addr_ff == STT_OFS_FLAGS &&
                   w_data_ff[STT_FL_P];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else begin
            compare_a_flag <= set_a || (compare_a_flag && !clr_a);
            compare_p_flag <= set_p || (compare_p_flag && !clr_p);
        end
    end

    // ------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------
    logic [16:0] duty_val;
    logic [16:0] per_val;
    logic pwm_on;
    logic nxt_lvl;

    assign duty_val = ctrl_dpx ? p_period : {1'b0, cmpa_ff};
    assign per_val = ctrl_dpx ? a_period : p_period;
    assign pwm_on = (duty_val >= per_val) || ({1'b0, cnt_ff} < duty_val);

    always_comb begin
        nxt_lvl = lvl_ff;
        if (run_rise) begin
            nxt_lvl = ctrl_oc;
        end else if (ctrl_mode == STT_MODE_CMP) begin
            if (set_a) begin
                unique case (ctrl_pfs)
                    STT_PFS_LOW: nxt_lvl = 1'b0;
                    STT_PFS_HIGH: nxt_lvl = 1'b1;
                    STT_PFS_TOGGLE: nxt_lvl = !lvl_ff;
                    STT_PFS_KEEP: nxt_lvl = lvl_ff;
                endcase
            end
        end else if (ctrl_mode == STT_MODE_PWM) begin
            unique case (ctrl_pfs)
                2'b00: nxt_lvl = !ctrl_oc;
                2'b01: nxt_lvl = ctrl_oc;
                2'b10: nxt_lvl = ctrl_run ? (pwm_on ? ctrl_oc : !ctrl_oc)
                                          : lvl_ff;
                2'b11: nxt_lvl = set_a ? !ctrl_oc : lvl_ff;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ff <= 1'b0;
            timer_output_pin <= 1'b0;
            timer_output_oe <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            timer_output_pin <= nxt_lvl ^ ctrl_inv;
            timer_output_oe <= (ctrl_mode == STT_MODE_CMP) ||
                               (ctrl_mode == STT_MODE_PWM);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_run_rise;
        !run_prev_ff ##0 ctrl_run;
    endsequence

    sequence s_steady_run;
        run_prev_ff && ctrl_run;
    endsequence

    chk_run_clear: assert property (s_run_rise |=> cnt_ff == 16'h0000)
        else $error("counter not cleared on run rise");
    chk_pause_hold: assert property ((ctrl_pau && run_prev_ff) |=>
        cnt_ff == $past(cnt_ff))
        else $error("counter moved while paused");
    chk_stop_hold: assert property ((!ctrl_run && run_prev_ff) ##1 !ctrl_run
        |=> cnt_ff == $past(cnt_ff, 2))
        else $error("counter moved while stopped");
    chk_count_step: assert property ((cnt_tick && !do_clear) |=>
        cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("counter did not step by one");
    chk_match_clear: assert property ((cnt_tick && do_clear) |=>
        cnt_ff == 16'h0000 && (compare_a_flag || compare_p_flag ||
        $past(cnt_ff) == 16'hFFFF))
        else $error("match clear missing");
    chk_p_suppress: assert property ((ctrl_cclr &&
        ctrl_mode != STT_MODE_PWM && !compare_p_flag) |=>
        !compare_p_flag)
        else $error("P flag raised while A clears");
    chk_init_level: assert property (s_run_rise |=>
        lvl_ff == $past(ctrl_oc))
        else $error("pin not at initial level");
    chk_ctrl0_low: assert property ((ar_take &&
        s_axi_araddr == STT_OFS_CTRL0) |=> s_axi_rdata[2:0] == 3'b000)
        else $error("reserved bits read nonzero");
    chk_full_duty: assert property ((s_steady_run ##0
        ctrl_mode == STT_MODE_PWM && ctrl_pfs == STT_PFS_HIGH &&
        duty_val >= per_val) |=> lvl_ff == ctrl_oc)
        else $error("full duty not held");
    chk_force_inv: assert property ((ctrl_mode == STT_MODE_PWM &&
        ctrl_pfs == STT_PFS_LOW && !run_rise) [*2] |=>
        timer_output_pin == (ctrl_oc ^ ctrl_inv))
        else $error("forced active level wrong");

endmodule // stt_timer

`default_nettype wire

// [test/stt_far_model.sv]
`timescale 1ns/1ps
`default_nettype none

module stt_far_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    output logic hs_clk_tick,
    output logic ls_clk_tick,
    output var logic ext_clock_pin
);
    logic [2:0] div_ff;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= 3'h0;
        end else begin
            div_ff <= div_ff + 3'h1;
        end
    end
    // Tick sources from one shared divider: hs every second cycle, ls every eighth
    assign hs_clk_tick = div_ff[0];
    assign ls_clk_tick = (div_ff == 3'h7);

    initial ext_clock_pin = 1'b0;
    // Pin idles low; pulses stay wide enough for the two-flop sync
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ext_clock_pin <= 1'b1;
            repeat (4) @(posedge clk_sys);
            ext_clock_pin <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
endmodule // stt_far_model

`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module tb
    import stt_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hs_clk_tick, ls_clk_tick, ext_clock_pin;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic timer_output_pin, timer_output_oe, compare_a_flag, compare_p_flag;
    int err_total = 0;
    int tests_run = 0;
    logic [33:0] notes[$];
    logic [7:0] regs[7] = '{STT_OFS_CTRL0, STT_OFS_CTRL1, STT_OFS_CNT_LO,
        STT_OFS_CNT_HI, STT_OFS_CMPA_LO, STT_OFS_CMPA_HI, STT_OFS_CMPP};
    logic [7:0] c1t[5] = '{8'h31, 8'h11, 8'h35, 8'h39, 8'h21};
    int nt[5] = '{6, 3, 0, 3, 3};
    logic et[5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] pwt[4] = '{8'h88, 8'h98, 8'ha8, 8'hb8};
    logic pwe[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic [2:0] ckt[5] = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101};
    int dvt[5] = '{4, 32, 128, 8, 8};

    always #2.5 clk_sys = ~clk_sys;

    stt_timer DUT (.clk_sys, .rst_n, .hs_clk_tick, .ls_clk_tick,
        .ext_clock_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .timer_output_pin, .timer_output_oe,
        .compare_a_flag, .compare_p_flag);

    stt_far_model far (.clk_sys, .rst_n, .hs_clk_tick, .ls_clk_tick,
        .ext_clock_pin);

    // ------------------------------------------------------------
    // Closing and bus tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] r = STT_RESP_OKAY,
            input logic [3:0] s = 4'hf);
        int n = 0;
        notes.push_back({r, 32'h0000_0000});
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Ready may lag valid by one random cycle
        s_axi_bready <= 1'($urandom);
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (!s_axi_bready) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
        s_axi_bready <= 1'b0;
        if (n >= 40) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d,
            input logic [1:0] r = STT_RESP_OKAY);
        int n = 0;
        notes.push_back({r, 24'h00_0000, d});
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'($urandom);
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (!s_axi_rready) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
        s_axi_rready <= 1'b0;
        if (n >= 40) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic check_note(input logic [33:0] got);
        logic [33:0] exp;
        exp = (notes.size() > 0) ? notes.pop_front() : 34'h3_ffff_ffff;
        `CHK(got, exp)
    endtask

    // Results are matched against the oldest expectation
    always @(posedge clk_sys) begin
        if (s_axi_bvalid && s_axi_bready) begin
            check_note({s_axi_bresp, 32'h0000_0000});
        end
        if (s_axi_rvalid && s_axi_rready) begin
            check_note({s_axi_rresp, s_axi_rdata});
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Stop before touching mode or pin function, then restart
    task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
        wr(STT_OFS_CTRL0, 8'h00);
        wr(STT_OFS_CTRL1, c1);
        wr(STT_OFS_FLAGS, 8'h03);
        wr(STT_OFS_CTRL0, c0);
    endtask

    task automatic cmp(input logic [15:0] a, input logic [7:0] p);
        wr(STT_OFS_CMPA_LO, a[7:0]);
        wr(STT_OFS_CMPA_HI, a[15:8]);
        wr(STT_OFS_CMPP, p);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] ra;
        ra = 8'($urandom(32'h1897));
        wt(20);
        rst_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(STT_OFS_CTRL0, 8'hf7);
        rd(STT_OFS_CTRL0, 8'hf0);
        wr(8'h20, 8'h55, STT_RESP_SLVERR);
        rd(8'h20, 8'h00, STT_RESP_SLVERR);
        ra = 8'($urandom);
        cmp({~ra, ra}, ra ^ 8'h5a);
        rd(STT_OFS_CMPA_LO, ra);
        rd(STT_OFS_CMPA_HI, ~ra);
        // Low strobe bit clear: the byte must not land
        wr(STT_OFS_CMPP, ~ra, STT_RESP_OKAY, {3'($urandom), 1'b0});
        rd(STT_OFS_CMPP, ra ^ 8'h5a);
        wr(STT_OFS_CNT_LO, 8'h5a);
        rd(STT_OFS_CNT_LO, 8'h00);
        cmp(16'h0000, 8'h00);
        wr(STT_OFS_CTRL0, 8'h68);
        far.ext_pulses(5);
        rd(STT_OFS_CNT_LO, 8'h05);
        rd(STT_OFS_CNT_HI, 8'h00);
        wr(STT_OFS_CTRL0, 8'he8);
        far.ext_pulses(3);
        rd(STT_OFS_CNT_LO, 8'h05);
        wr(STT_OFS_CTRL0, 8'h68);
        far.ext_pulses(2);
        rd(STT_OFS_CNT_LO, 8'h07);
        wr(STT_OFS_CTRL0, 8'h60);
        far.ext_pulses(2);
        rd(STT_OFS_CNT_LO, 8'h07);
        wr(STT_OFS_CTRL0, 8'h78);
        rd(STT_OFS_CNT_LO, 8'h00);
        far.ext_pulses(1);
        rd(STT_OFS_CNT_LO, 8'h01);
        cmp(16'h0003, 8'h00);
        cfg(8'h68, 8'h31);
        wt(6);
        `CHK(timer_output_pin, 1'b0)
        far.ext_pulses(2);
        `CHK(compare_a_flag, 1'b0)
        far.ext_pulses(1);
        wt(6);
        `CHK(compare_a_flag, 1'b1)
        `CHK(compare_p_flag, 1'b0)
        `CHK(timer_output_pin, 1'b1)
        rd(STT_OFS_CNT_LO, 8'h00);
        for (int i = 0; i < 5; i++) begin
            cfg(8'h68, c1t[i]);
            far.ext_pulses(nt[i]);
            wt(6);
            `CHK(timer_output_pin, et[i])
        end
        for (int m = 0; m < 4; m++) begin
            cfg(8'h68, {2'(m), 6'h00});
            wt(4);
            `CHK(timer_output_oe, 1'(m % 2 == 0))
        end
        // Every divided source: match at 8 ticks lies between the looks
        cmp(16'h0008, 8'h00);
        foreach (ckt[i]) begin
            cfg({1'b0, ckt[i], 4'h8}, 8'h01);
            wt(6 * dvt[i]);
            `CHK(compare_a_flag, 1'b0)
            wt(4 * dvt[i]);
            `CHK(compare_a_flag, 1'b1)
        end
        cmp({8'h00, 8'h10 + {2'b00, ra[5:0]}}, 8'h01);
        cfg(8'h18, 8'h00);
        wt(200);
        `CHK(compare_p_flag, 1'b0)
        `CHK(compare_a_flag, 1'b1)
        wt(100);
        `CHK(compare_p_flag, 1'b1)
        cmp(16'h1000, 8'h01);
        // Clear by A: the P match at 256 passes without flag or clear
        cfg(8'h18, 8'h01);
        wt(600);
        `CHK(compare_p_flag, 1'b0)
        `CHK(compare_a_flag, 1'b0)
        rd(STT_OFS_CNT_HI, 8'h02);
        for (int i = 0; i < 4; i++) begin
            cfg(8'h18, pwt[i]);
            wt(6);
            `CHK(timer_output_pin, pwe[i])
        end
        cfg(8'h18, 8'ha8);
        wt(6);
        repeat (300) begin
            @(posedge clk_sys);
            `CHK(timer_output_pin, 1'b1)
        end
        cfg(8'h18, 8'haa);
        wt(100);
        `CHK(timer_output_pin, 1'b1)
        wt(400);
        `CHK(timer_output_pin, 1'b0)
        wt(4);
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
